// ==== arg_pkg.sv ====
// Register map, field layout, reset values and source codes of the audio routing and gain control
package arg_pkg;
  // Register byte offsets
  localparam logic [7:0] LOOP_CTRL_OFS = 8'h00;
  localparam logic [7:0] ROUTE_CTRL_OFS = 8'h04;
  localparam logic [7:0] ANALOG_CTRL_OFS = 8'h08;
  localparam logic [7:0] MIC_CTRL_OFS = 8'h0C;
  localparam logic [7:0] ADC_GAIN_OFS = 8'h10;
  localparam logic [7:0] DAC_VOL_OFS = 8'h14;
  localparam logic [7:0] HP_VOL_OFS = 8'h18;
  localparam logic [7:0] LINE_LEVEL_OFS = 8'h1C;
  localparam logic [7:0] STATUS_OFS = 8'h20;
  // Clock loop control fields
  localparam int INT_DIV_LSB = 0;
  localparam int INT_DIV_W = 5;
  localparam int FRAC_DIV_LSB = 5;
  localparam int FRAC_DIV_W = 11;
  localparam int HALVE_BIT = 16;
  // Routing control fields, one selector per destination
  localparam int DAC_SEL_LSB = 0;
  localparam int ENGINE_SEL_LSB = 4;
  localparam int SEROUT_SEL_LSB = 8;
  localparam int SEL_W = 2;
  // Analog path control bits
  localparam int HP_SRC_BIT = 0;
  localparam int ADC_SRC_BIT = 1;
  localparam int HP_MUTE_BIT = 2;
  localparam int LO_MUTE_BIT = 3;
  localparam int ADC_ZC_BIT = 4;
  localparam int HP_ZC_BIT = 5;
  // Mic, gain, volume fields
  localparam int MIC_BIAS_LSB = 0;
  localparam int MIC_BIAS_W = 3;
  localparam int MIC_GAIN_LSB = 4;
  localparam int MIC_GAIN_W = 2;
  localparam int ADC_GAIN_LSB = 0;
  localparam int ADC_GAIN_W = 4;
  localparam int ADC_SHIFT_BIT = 8;
  localparam int VOL_W = 8;
  localparam int LINE_LEVEL_W = 5;
  // Status fields
  localparam int ST_ADC_GAIN_LSB = 0;
  localparam int ST_HP_VOL_LSB = 8;
  localparam int ST_ADC_PEND_BIT = 16;
  localparam int ST_HP_PEND_BIT = 17;
  // Volume code limits: DAC 0x3C is 0 dB, 0xF0 is -90 dB; headphone 0x00 is +12 dB, 0x80 is -52 dB
  localparam logic [7:0] DAC_VOL_MAX = 8'h3C;
  localparam logic [7:0] DAC_VOL_MIN = 8'hF0;
  localparam logic [7:0] HP_VOL_MAX = 8'h00;
  localparam logic [7:0] HP_VOL_MIN = 8'h80;
  // Source codes of the routing switch
  localparam logic [1:0] SRC_ADC = 2'h0;
  localparam logic [1:0] SRC_SERIAL = 2'h1;
  localparam logic [1:0] SRC_ENGINE = 2'h3;
  // Reset values
  localparam logic [31:0] LOOP_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] DAC_SEL_RST = 2'h1;
  localparam logic [1:0] ENGINE_SEL_RST = 2'h0;
  localparam logic [1:0] SEROUT_SEL_RST = 2'h0;
  localparam logic [5:0] ANALOG_CTRL_RST = 6'h0C;
  localparam logic [5:0] MIC_CTRL_RST = 6'h00;
  localparam logic [3:0] ADC_GAIN_RST = 4'h0;
  localparam logic [7:0] DAC_VOL_RST = 8'h3C;
  localparam logic [7:0] HP_VOL_RST = 8'h18;
  localparam logic [4:0] LINE_LEVEL_RST = 5'h00;
endpackage : arg_pkg

// ==== arg_route_gain.sv ====
// Audio routing switch, clock loop setup and gain, mute and bypass controls behind an APB slave
//
// The placing of the registers and the APB slave port are this design's own decisions.
module arg_route_gain #(
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB register port
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Audio sources
  input wire logic [DW-1:0] adc_data,
  input wire logic adc_valid,
  input wire logic [DW-1:0] serial_in_data,
  input wire logic serial_in_valid,
  input wire logic [DW-1:0] engine_out_data,
  input wire logic engine_out_valid,
  // Audio destinations
  output logic [DW-1:0] dac_in_data,
  output logic dac_in_valid,
  output logic [DW-1:0] engine_in_data,
  output logic engine_in_valid,
  output logic [DW-1:0] serial_out_data,
  output logic serial_out_valid,
  // Zero-crossing pulses from the analog comparators
  input wire logic adc_zero_cross,
  input wire logic hp_zero_cross,
  // Clock loop settings
  output logic [4:0] loop_integer_divisor,
  output logic [10:0] loop_fraction_divisor,
  output logic input_clock_halve,
  // Analog path settings
  output logic headphone_source_select,
  output logic adc_source_mic,
  output logic headphone_mute,
  output logic line_output_mute,
  output logic [2:0] mic_bias_code,
  output logic [1:0] mic_gain_code,
  output logic [3:0] adc_gain_code,
  output logic adc_range_shift,
  output logic [7:0] converter_digital_volume,
  output logic [7:0] headphone_volume,
  output logic [4:0] line_output_level
);
  logic [31:0] loop_ctrl_ff, nxt_loop_ctrl;
  logic [1:0] dac_sel_ff, nxt_dac_sel;
  logic [1:0] engine_sel_ff, nxt_engine_sel;
  logic [1:0] serout_sel_ff, nxt_serout_sel;
  logic [5:0] analog_ff, nxt_analog;
  logic [5:0] mic_ff, nxt_mic;
  logic [3:0] adc_gain_req_ff, nxt_adc_gain_req;
  logic adc_shift_ff, nxt_adc_shift;
  logic [7:0] dac_vol_ff, nxt_dac_vol;
  logic [7:0] hp_vol_req_ff, nxt_hp_vol_req;
  logic [4:0] line_level_ff, nxt_line_level;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [DW-1:0] dac_data_ff, nxt_dac_data;
  logic [DW-1:0] engine_data_ff, nxt_engine_data;
  logic [DW-1:0] serout_data_ff, nxt_serout_data;
  logic dac_valid_ff, nxt_dac_valid;
  logic engine_valid_ff, nxt_engine_valid;
  logic serout_valid_ff, nxt_serout_valid;
  logic access;
  logic wr_take;
  logic mapped;

  arg_zc_if #(.W(4)) adc_zc();
  arg_zc_if #(.W(8)) hp_zc();

  // Out-of-range volume writes are pulled to the nearest end of the range
  function automatic logic [7:0] arg_clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    arg_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : arg_clamp

  // Code 2 is unused and drives a silent, idle stream
  function automatic logic [DW:0] arg_pick(input logic [1:0] sel, input logic [DW:0] adc_s,
                                           input logic [DW:0] ser_s, input logic [DW:0] eng_s);
    unique case (sel)
      arg_pkg::SRC_ADC: arg_pick = adc_s;
      arg_pkg::SRC_SERIAL: arg_pick = ser_s;
      arg_pkg::SRC_ENGINE: arg_pick = eng_s;
      default: arg_pick = '0;
    endcase
  endfunction : arg_pick

  function automatic logic arg_mapped(input logic [7:0] a);
    arg_mapped = (a[1:0] == 2'h0) && (a <= arg_pkg::STATUS_OFS);
  endfunction : arg_mapped

  assign access = psel && penable;
  assign wr_take = access && pwrite && pready_ff && mapped;
  assign mapped = arg_mapped(paddr);

  // One wait state: pready rises in the second access cycle and falls after it
  always_comb begin
    nxt_pready = access && !pready_ff;
    nxt_pslverr = access && !pready_ff && !mapped;
    nxt_prdata = '0;
    if (access && !pready_ff && !pwrite) begin
      unique case (paddr)
        arg_pkg::LOOP_CTRL_OFS: nxt_prdata = loop_ctrl_ff;
        arg_pkg::ROUTE_CTRL_OFS: begin
          nxt_prdata[arg_pkg::DAC_SEL_LSB +: arg_pkg::SEL_W] = dac_sel_ff;
          nxt_prdata[arg_pkg::ENGINE_SEL_LSB +: arg_pkg::SEL_W] = engine_sel_ff;
          nxt_prdata[arg_pkg::SEROUT_SEL_LSB +: arg_pkg::SEL_W] = serout_sel_ff;
        end
        arg_pkg::ANALOG_CTRL_OFS: nxt_prdata[5:0] = analog_ff;
        arg_pkg::MIC_CTRL_OFS: nxt_prdata[5:0] = mic_ff;
        arg_pkg::ADC_GAIN_OFS: begin
          nxt_prdata[arg_pkg::ADC_GAIN_LSB +: arg_pkg::ADC_GAIN_W] = adc_gain_req_ff;
          nxt_prdata[arg_pkg::ADC_SHIFT_BIT] = adc_shift_ff;
        end
        arg_pkg::DAC_VOL_OFS: nxt_prdata[arg_pkg::VOL_W-1:0] = dac_vol_ff;
        arg_pkg::HP_VOL_OFS: nxt_prdata[arg_pkg::VOL_W-1:0] = hp_vol_req_ff;
        arg_pkg::LINE_LEVEL_OFS: nxt_prdata[arg_pkg::LINE_LEVEL_W-1:0] = line_level_ff;
        arg_pkg::STATUS_OFS: begin
          nxt_prdata[arg_pkg::ST_ADC_GAIN_LSB +: arg_pkg::ADC_GAIN_W] = adc_zc.applied;
          nxt_prdata[arg_pkg::ST_HP_VOL_LSB +: arg_pkg::VOL_W] = hp_zc.applied;
          nxt_prdata[arg_pkg::ST_ADC_PEND_BIT] = adc_zc.pending;
          nxt_prdata[arg_pkg::ST_HP_PEND_BIT] = hp_zc.pending;
        end
        default: nxt_prdata = '0;
      endcase
    end
  end

  // Control registers; status is read-only and writes to it are dropped
  always_comb begin
    nxt_loop_ctrl = loop_ctrl_ff;
    nxt_dac_sel = dac_sel_ff;
    nxt_engine_sel = engine_sel_ff;
    nxt_serout_sel = serout_sel_ff;
    nxt_analog = analog_ff;
    nxt_mic = mic_ff;
    nxt_adc_gain_req = adc_gain_req_ff;
    nxt_adc_shift = adc_shift_ff;
    nxt_dac_vol = dac_vol_ff;
    nxt_hp_vol_req = hp_vol_req_ff;
    nxt_line_level = line_level_ff;
    if (wr_take) begin
      unique case (paddr)
        arg_pkg::LOOP_CTRL_OFS: begin
          nxt_loop_ctrl = '0;
          nxt_loop_ctrl[arg_pkg::INT_DIV_LSB +: arg_pkg::INT_DIV_W] = pwdata[arg_pkg::INT_DIV_LSB +: arg_pkg::INT_DIV_W];
          nxt_loop_ctrl[arg_pkg::FRAC_DIV_LSB +: arg_pkg::FRAC_DIV_W] =
            pwdata[arg_pkg::FRAC_DIV_LSB +: arg_pkg::FRAC_DIV_W];
          nxt_loop_ctrl[arg_pkg::HALVE_BIT] = pwdata[arg_pkg::HALVE_BIT];
        end
        arg_pkg::ROUTE_CTRL_OFS: begin
          nxt_dac_sel = pwdata[arg_pkg::DAC_SEL_LSB +: arg_pkg::SEL_W];
          nxt_serout_sel = pwdata[arg_pkg::SEROUT_SEL_LSB +: arg_pkg::SEL_W];
          // A loop through the engine would feed its own output back; keep the old source
          if (pwdata[arg_pkg::ENGINE_SEL_LSB +: arg_pkg::SEL_W] != arg_pkg::SRC_ENGINE) begin
            nxt_engine_sel = pwdata[arg_pkg::ENGINE_SEL_LSB +: arg_pkg::SEL_W];
          end
        end
        arg_pkg::ANALOG_CTRL_OFS: nxt_analog = pwdata[5:0];
        arg_pkg::MIC_CTRL_OFS: begin
          nxt_mic = '0;
          nxt_mic[arg_pkg::MIC_BIAS_LSB +: arg_pkg::MIC_BIAS_W] = pwdata[arg_pkg::MIC_BIAS_LSB +: arg_pkg::MIC_BIAS_W];
          nxt_mic[arg_pkg::MIC_GAIN_LSB +: arg_pkg::MIC_GAIN_W] = pwdata[arg_pkg::MIC_GAIN_LSB +: arg_pkg::MIC_GAIN_W];
        end
        arg_pkg::ADC_GAIN_OFS: begin
          nxt_adc_gain_req = pwdata[arg_pkg::ADC_GAIN_LSB +: arg_pkg::ADC_GAIN_W];
          nxt_adc_shift = pwdata[arg_pkg::ADC_SHIFT_BIT];
        end
        arg_pkg::DAC_VOL_OFS:
          nxt_dac_vol = arg_clamp(pwdata[7:0], arg_pkg::DAC_VOL_MAX, arg_pkg::DAC_VOL_MIN);
        arg_pkg::HP_VOL_OFS:
          nxt_hp_vol_req = arg_clamp(pwdata[7:0], arg_pkg::HP_VOL_MAX, arg_pkg::HP_VOL_MIN);
        arg_pkg::LINE_LEVEL_OFS: nxt_line_level = pwdata[arg_pkg::LINE_LEVEL_W-1:0];
        default: nxt_loop_ctrl = loop_ctrl_ff;
      endcase
    end
  end

  // Routing switch: each destination follows its own selector, one cycle late
  always_comb begin
    {nxt_dac_valid, nxt_dac_data} = arg_pick(dac_sel_ff, {adc_valid, adc_data},
      {serial_in_valid, serial_in_data}, {engine_out_valid, engine_out_data});
    {nxt_engine_valid, nxt_engine_data} = arg_pick(engine_sel_ff, {adc_valid, adc_data},
      {serial_in_valid, serial_in_data}, {engine_out_valid, engine_out_data});
    {nxt_serout_valid, nxt_serout_data} = arg_pick(serout_sel_ff, {adc_valid, adc_data},
      {serial_in_valid, serial_in_data}, {engine_out_valid, engine_out_data});
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loop_ctrl_ff <= arg_pkg::LOOP_CTRL_RST;
      dac_sel_ff <= arg_pkg::DAC_SEL_RST;
      engine_sel_ff <= arg_pkg::ENGINE_SEL_RST;
      serout_sel_ff <= arg_pkg::SEROUT_SEL_RST;
      analog_ff <= arg_pkg::ANALOG_CTRL_RST;
      mic_ff <= arg_pkg::MIC_CTRL_RST;
      adc_gain_req_ff <= arg_pkg::ADC_GAIN_RST;
      adc_shift_ff <= 1'b0;
      dac_vol_ff <= arg_pkg::DAC_VOL_RST;
      hp_vol_req_ff <= arg_pkg::HP_VOL_RST;
      line_level_ff <= arg_pkg::LINE_LEVEL_RST;
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      loop_ctrl_ff <= nxt_loop_ctrl;
      dac_sel_ff <= nxt_dac_sel;
      engine_sel_ff <= nxt_engine_sel;
      serout_sel_ff <= nxt_serout_sel;
      analog_ff <= nxt_analog;
      mic_ff <= nxt_mic;
      adc_gain_req_ff <= nxt_adc_gain_req;
      adc_shift_ff <= nxt_adc_shift;
      dac_vol_ff <= nxt_dac_vol;
      hp_vol_req_ff <= nxt_hp_vol_req;
      line_level_ff <= nxt_line_level;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dac_data_ff <= '0;
      engine_data_ff <= '0;
      serout_data_ff <= '0;
      dac_valid_ff <= 1'b0;
      engine_valid_ff <= 1'b0;
      serout_valid_ff <= 1'b0;
    end else begin
      dac_data_ff <= nxt_dac_data;
      engine_data_ff <= nxt_engine_data;
      serout_data_ff <= nxt_serout_data;
      dac_valid_ff <= nxt_dac_valid;
      engine_valid_ff <= nxt_engine_valid;
      serout_valid_ff <= nxt_serout_valid;
    end
  end

  // ADC gain and headphone volume changes wait for a zero crossing when gating is on, to avoid pops
  assign adc_zc.enable = analog_ff[arg_pkg::ADC_ZC_BIT];
  assign adc_zc.request = adc_gain_req_ff;
  assign adc_zc.crossing = adc_zero_cross;
  assign hp_zc.enable = analog_ff[arg_pkg::HP_ZC_BIT];
  assign hp_zc.request = hp_vol_req_ff;
  assign hp_zc.crossing = hp_zero_cross;

  arg_zero_cross_gate #(.W(4), .RESET_VAL(arg_pkg::ADC_GAIN_RST)) u_adc_gate (
    .clock(clock),
    .rst_b(rst_b),
    .zc(adc_zc.gate)
  );

  arg_zero_cross_gate #(.W(8), .RESET_VAL(arg_pkg::HP_VOL_RST)) u_hp_gate (
    .clock(clock),
    .rst_b(rst_b),
    .zc(hp_zc.gate)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign dac_in_data = dac_data_ff;
  assign dac_in_valid = dac_valid_ff;
  assign engine_in_data = engine_data_ff;
  assign engine_in_valid = engine_valid_ff;
  assign serial_out_data = serout_data_ff;
  assign serial_out_valid = serout_valid_ff;
  // Loop settings go to the clock multiplier that derives every audio clock
  assign loop_integer_divisor = loop_ctrl_ff[arg_pkg::INT_DIV_LSB +: arg_pkg::INT_DIV_W];
  assign loop_fraction_divisor = loop_ctrl_ff[arg_pkg::FRAC_DIV_LSB +: arg_pkg::FRAC_DIV_W];
  assign input_clock_halve = loop_ctrl_ff[arg_pkg::HALVE_BIT];
  // In bypass the headphone amp takes line input, so only its own volume and mute apply
  assign headphone_source_select = analog_ff[arg_pkg::HP_SRC_BIT];
  assign adc_source_mic = analog_ff[arg_pkg::ADC_SRC_BIT];
  assign headphone_mute = analog_ff[arg_pkg::HP_MUTE_BIT];
  assign line_output_mute = analog_ff[arg_pkg::LO_MUTE_BIT];
  assign mic_bias_code = mic_ff[arg_pkg::MIC_BIAS_LSB +: arg_pkg::MIC_BIAS_W];
  assign mic_gain_code = mic_ff[arg_pkg::MIC_GAIN_LSB +: arg_pkg::MIC_GAIN_W];
  assign adc_gain_code = adc_zc.applied;
  assign adc_range_shift = adc_shift_ff;
  assign converter_digital_volume = dac_vol_ff;
  assign headphone_volume = hp_zc.applied;
  assign line_output_level = line_level_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  engine_no_loop_a: assert property (engine_sel_ff != arg_pkg::SRC_ENGINE)
    else $error("engine input selects its own output");
  dac_from_engine_a: assert property (dac_sel_ff == arg_pkg::SRC_ENGINE && $stable(dac_sel_ff)
      |=> dac_in_data == $past(engine_out_data) && dac_in_valid == $past(engine_out_valid))
    else $error("DAC not fed from engine output");
  engine_from_serial_a: assert property (engine_sel_ff == arg_pkg::SRC_SERIAL
      |=> engine_in_data == $past(serial_in_data))
    else $error("engine not fed from serial input");
  fan_out_a: assert property (dac_sel_ff == serout_sel_ff && dac_sel_ff != 2'h2
      |=> dac_in_data == serial_out_data)
    else $error("shared source differs between outputs");
  dac_vol_range_a: assert property (converter_digital_volume >= arg_pkg::DAC_VOL_MAX
      && converter_digital_volume <= arg_pkg::DAC_VOL_MIN)
    else $error("DAC volume out of range");
  hp_vol_range_a: assert property (headphone_volume <= arg_pkg::HP_VOL_MIN)
    else $error("headphone volume out of range");
  apb_wait_a: assert property (access && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle long");
  route_write_a: assert property (wr_take && paddr == arg_pkg::ROUTE_CTRL_OFS
      |=> dac_sel_ff == $past(pwdata[1:0]))
    else $error("DAC selector not written");
  hp_mute_write_a: assert property (wr_take && paddr == arg_pkg::ANALOG_CTRL_OFS
      |=> headphone_mute == $past(pwdata[2]) && headphone_source_select == $past(pwdata[0]))
    else $error("headphone mute or source not written");
  adc_shift_a: assert property (wr_take && paddr == arg_pkg::ADC_GAIN_OFS
      |=> adc_range_shift == $past(pwdata[8]))
    else $error("range shift bit not written");

  route_engine_c: cover property (engine_sel_ff == arg_pkg::SRC_SERIAL && dac_sel_ff == arg_pkg::SRC_ENGINE);
  bypass_c: cover property (headphone_source_select && !headphone_mute);
  apb_error_c: cover property (pready && pslverr);
endmodule : arg_route_gain

// ==== arg_route_gain_tb.sv ====
// Self-checking testbench of the routing, clock loop and gain controls
module arg_route_gain_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 32;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, err_v;
  logic [7:0] paddr, dvol, hvol;
  logic [31:0] pwdata, prdata, rd_v, seed, v;
  logic [DW-1:0] ad, sd, ed, dd, eid, sod;
  logic av, sv, ev, dv, eiv, sov, azc, hzc, halve, hps, amic, hpm, lom, shf;
  logic [4:0] idiv, lvl;
  logic [10:0] fdiv;
  logic [2:0] bias;
  logic [1:0] mg, ds, es, ss, cur_e;
  logic [3:0] ag;
  logic [DW:0] pa, ps, pe;
  int errors, tests_run, cyc;

  arg_src_model #(.DW(DW)) arg_src_model_i (.clock(clock), .rst_b(rst_b), .adc_data(ad), .adc_valid(av),
    .serial_in_data(sd), .serial_in_valid(sv), .engine_out_data(ed), .engine_out_valid(ev));
  arg_route_gain #(.DW(DW)) arg_route_gain_i (.clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_data(ad), .adc_valid(av), .serial_in_data(sd), .serial_in_valid(sv), .engine_out_data(ed),
    .engine_out_valid(ev), .dac_in_data(dd), .dac_in_valid(dv), .engine_in_data(eid), .engine_in_valid(eiv),
    .serial_out_data(sod), .serial_out_valid(sov), .adc_zero_cross(azc), .hp_zero_cross(hzc),
    .loop_integer_divisor(idiv), .loop_fraction_divisor(fdiv), .input_clock_halve(halve),
    .headphone_source_select(hps), .adc_source_mic(amic), .headphone_mute(hpm), .line_output_mute(lom),
    .mic_bias_code(bias), .mic_gain_code(mg), .adc_gain_code(ag), .adc_range_shift(shf),
    .converter_digital_volume(dvol), .headphone_volume(hvol), .line_output_level(lvl));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Sources as the design saw them at the last edge
  always @(posedge clock) begin
    pa <= {av, ad};
    ps <= {sv, sd};
    pe <= {ev, ed};
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function logic [DW:0] src(input logic [1:0] c);
    case (c)
      arg_pkg::SRC_ADC: return pa;
      arg_pkg::SRC_SERIAL: return ps;
      arg_pkg::SRC_ENGINE: return pe;
      default: return '0;
    endcase
  endfunction : src
  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never gets an answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(negedge clock);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e);
    chk(err_v, 1'b0);
  endtask : rd
  task final_report();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  initial begin
    seed = 32'h20;
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, azc, hzc} = '0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd(arg_pkg::ANALOG_CTRL_OFS, 32'(arg_pkg::ANALOG_CTRL_RST));
    rd(arg_pkg::DAC_VOL_OFS, 32'(arg_pkg::DAC_VOL_RST));
    rd(arg_pkg::ROUTE_CTRL_OFS, 32'(arg_pkg::DAC_SEL_RST));
    // Loop fields stay zero until the host programs them; the bench clock stands for a 256x master clock
    rd(arg_pkg::LOOP_CTRL_OFS, arg_pkg::LOOP_CTRL_RST);
    $display("reset values done");
    // 12 MHz master clock, below the halving limit
    wr(arg_pkg::LOOP_CTRL_OFS, {15'h0, 1'b0, 11'h312, 5'h10});
    chk({halve, fdiv, idiv}, {1'b0, 11'h312, 5'h10});
    cur_e = arg_pkg::ENGINE_SEL_RST;
    for (int i = 0; i < 12; i++) begin
      v = xs();
      ds = (i < 4) ? 2'(i) : v[1:0];
      es = (i < 4) ? 2'(3 - i) : v[5:4];
      ss = v[9:8];
      wr(arg_pkg::ROUTE_CTRL_OFS, {v[31:10], ss, 2'h0, es, 2'h0, ds});
      if (es != arg_pkg::SRC_ENGINE) cur_e = es;
      @(negedge clock);
      chk({dv, dd}, src(ds));
      chk({eiv, eid}, src(cur_e));
      chk({sov, sod}, src(ss));
    end
    $display("routing done");
    for (int b = 0; b < 4; b++) begin
      wr(arg_pkg::ANALOG_CTRL_OFS, 32'h1 << b);
      chk({lom, hpm, amic, hps}, 4'h1 << b);
    end
    for (int b = 0; b < 8; b++) begin
      wr(arg_pkg::MIC_CTRL_OFS, {26'h0, 2'(b), 1'b0, 3'(b)});
      chk({mg, bias}, {2'(b), 3'(b)});
    end
    for (int b = 0; b < 16; b++) begin
      wr(arg_pkg::ADC_GAIN_OFS, {23'h0, b[0], 4'h0, 4'(b)});
      // Applied gain follows the request one cycle after the write edge
      @(negedge clock);
      chk({shf, ag}, {b[0], 4'(b)});
    end
    wr(arg_pkg::DAC_VOL_OFS, 32'hFF);
    chk(dvol, arg_pkg::DAC_VOL_MIN);
    wr(arg_pkg::DAC_VOL_OFS, 32'h0);
    chk(dvol, arg_pkg::DAC_VOL_MAX);
    wr(arg_pkg::HP_VOL_OFS, 32'hFF);
    @(negedge clock);
    chk(hvol, arg_pkg::HP_VOL_MIN);
    wr(arg_pkg::HP_VOL_OFS, 32'h0);
    @(negedge clock);
    chk(hvol, arg_pkg::HP_VOL_MAX);
    v = xs();
    wr(arg_pkg::LINE_LEVEL_OFS, v);
    chk(lvl, v[arg_pkg::LINE_LEVEL_W-1:0]);
    $display("controls done");
    wr(arg_pkg::ANALOG_CTRL_OFS, 32'h30);
    wr(arg_pkg::HP_VOL_OFS, 32'h40);
    wr(arg_pkg::ADC_GAIN_OFS, 32'h7);
    chk({hvol, ag}, {8'h00, 4'hF});
    rd(arg_pkg::STATUS_OFS, 32'h0003_000F);
    @(posedge clock);
    azc <= 1'b1;
    hzc <= 1'b1;
    @(posedge clock);
    azc <= 1'b0;
    hzc <= 1'b0;
    @(negedge clock);
    chk({hvol, ag}, {8'h40, 4'h7});
    rd(arg_pkg::STATUS_OFS, 32'h0000_4007);
    apb(1'b0, 8'h24, 32'h0);
    chk({err_v, rd_v}, {1'b1, 32'h0});
    apb(1'b1, 8'h06, 32'h0);
    chk(err_v, 1'b1);
    $display("zero cross and errors done");
    final_report();
  end
endmodule : arg_route_gain_tb

// ==== arg_src_model.sv ====
// Model of the audio sources that feed the routing switch
module arg_src_model #(
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Source streams
  output logic [DW-1:0] adc_data,
  output logic adc_valid,
  output logic [DW-1:0] serial_in_data,
  output logic serial_in_valid,
  output logic [DW-1:0] engine_out_data,
  output logic engine_out_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // Distinct pattern per source, so a wrong selector shows up as a data mismatch
  assign adc_data = DW'({8'hA0, cnt_ff});
  assign serial_in_data = DW'({8'h51, cnt_ff});
  assign engine_out_data = DW'({8'hE3, cnt_ff});
  assign adc_valid = cnt_ff[0];
  assign serial_in_valid = 1'b1;
  assign engine_out_valid = cnt_ff[1];
endmodule : arg_src_model

// ==== arg_zc_if.sv ====
// Carrier between the control core and a zero-crossing gate
interface arg_zc_if #(parameter int W = 8);
  logic enable;
  logic [W-1:0] request;
  logic crossing;
  logic [W-1:0] applied;
  logic pending;
  modport gate (input enable, input request, input crossing, output applied, output pending);
  modport user (output enable, output request, output crossing, input applied, input pending);
endinterface : arg_zc_if

// ==== arg_zero_cross_gate.sv ====
// Holds a gain setting back until the audio crosses zero, when that gating is enabled
module arg_zero_cross_gate #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Gain request and applied value
  arg_zc_if.gate zc
);
  logic [W-1:0] applied_ff;
  logic [W-1:0] nxt_applied;
  logic pending_ff;
  logic nxt_pending;

  always_comb begin
    nxt_applied = applied_ff;
    if (!zc.enable || zc.crossing) begin
      nxt_applied = zc.request;
    end
    nxt_pending = (nxt_applied != zc.request);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      applied_ff <= RESET_VAL;
      pending_ff <= 1'b0;
    end else begin
      applied_ff <= nxt_applied;
      pending_ff <= nxt_pending;
    end
  end

  assign zc.applied = applied_ff;
  assign zc.pending = pending_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  zc_hold_a: assert property (zc.enable && !zc.crossing |=> applied_ff == $past(applied_ff))
    else $error("gain changed without a zero crossing");
  zc_pass_a: assert property (!zc.enable |=> applied_ff == $past(zc.request))
    else $error("gain not applied at once with gating off");
  zc_take_a: assert property (zc.enable && zc.crossing |=> applied_ff == $past(zc.request) && !pending_ff)
    else $error("gain not applied at zero crossing");
  zc_wait_c: cover property (zc.enable && pending_ff ##1 pending_ff [*3] ##1 !pending_ff);
endmodule : arg_zero_cross_gate
